// file: pkg/cmp_exec_pkg.sv
package cmp_exec_pkg;

	// Opcodes handled by this datapath.
	localparam logic [7:0] OP_CPL_CARRY = 8'hF5;
	localparam logic [7:0] OP_CMP_RMR8 = 8'h38;
	localparam logic [7:0] OP_CMP_RMR16 = 8'h39;
	localparam logic [7:0] OP_CMP_RRM8 = 8'h3A;
	localparam logic [7:0] OP_CMP_RRM16 = 8'h3B;
	localparam logic [7:0] OP_CMP_ACC8 = 8'h3C;
	localparam logic [7:0] OP_CMP_ACC16 = 8'h3D;
	localparam logic [7:0] OP_GRP_I8   = 8'h80;
	localparam logic [7:0] OP_GRP_I16  = 8'h81;
	localparam logic [7:0] OP_GRP_SX8  = 8'h83;
	localparam logic [7:0] OP_STR_CMP8 = 8'hA6;
	localparam logic [7:0] OP_STR_CMP16 = 8'hA7;
	localparam logic [2:0] GRP_CMP_REG = 3'h7;

	// Execution lengths in core clocks.
	localparam logic [4:0] CLK_CPL_CARRY = 5'h02;
	localparam logic [4:0] CLK_CMP_REG  = 5'h03;
	localparam logic [4:0] CLK_CMP_ACCW = 5'h04;
	localparam logic [4:0] CLK_CMP_MEM  = 5'h0A;
	localparam logic [4:0] CLK_CMP_MEMN = 5'h0E;
	localparam logic [4:0] CLK_STR      = 5'h16;
	localparam logic [4:0] CLK_STR_NW   = 5'h1A;

	// Index steps per operand size.
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;

	// Flag vector bit positions.
	localparam int FL_CARRY = 0;
	localparam int FL_PF = 1;
	localparam int FL_AF = 2;
	localparam int FL_ZF = 3;
	localparam int FL_SF = 4;
	localparam int FL_OF = 5;
	localparam logic [5:0] FLAGS_RST = 6'h00;

	// Segment selector codes.
	typedef enum logic [1:0] {SEG_EXTRA, SEG_CS, SEG_SS, SEG_DATA} seg_t;

	// Operation classes after decode.
	typedef enum logic [1:0] {OPC_NONE, OPC_CPL, OPC_CMP, OPC_STR} opclass_t;

endpackage

// file: pkg/sub_flags_if.sv
`timescale 1ns/1ps
interface sub_flags_if;
	logic [15:0] minuend;
	logic [15:0] subtrahend;
	logic        wordOp;
	logic [5:0]  flags;

	modport core (output minuend, output subtrahend, output wordOp, input flags);
	modport alu  (input minuend, input subtrahend, input wordOp, output flags);
endinterface

// file: hdl/sub_flag_unit.sv
`timescale 1ns/1ps
module sub_flag_unit
(
	sub_flags_if.alu sub
);
	wire [16:0] diff  = {1'b0, sub.minuend} - {1'b0, sub.subtrahend};
	wire [8:0]  diffB = {1'b0, sub.minuend[7:0]} - {1'b0, sub.subtrahend[7:0]};
	wire [4:0]  diffN = {1'b0, sub.minuend[3:0]} - {1'b0, sub.subtrahend[3:0]};
	wire        msbA  = sub.wordOp ? sub.minuend[15] : sub.minuend[7];
	wire        msbB  = sub.wordOp ? sub.subtrahend[15] : sub.subtrahend[7];
	wire        msbD  = sub.wordOp ? diff[15] : diffB[7];
	wire        borrow = sub.wordOp ? diff[16] : diffB[8];
	wire        zero  = sub.wordOp ? (diff[15:0] == 16'h0000) : (diffB[7:0] == 8'h00);

	// Flags follow a plain subtraction; carry is the borrow.
	assign sub.flags[cmp_exec_pkg::FL_CARRY] = borrow;
	assign sub.flags[cmp_exec_pkg::FL_PF] = ~^diffB[7:0];
	assign sub.flags[cmp_exec_pkg::FL_AF] = diffN[4];
	assign sub.flags[cmp_exec_pkg::FL_ZF] = zero;
	assign sub.flags[cmp_exec_pkg::FL_SF] = msbD;
	assign sub.flags[cmp_exec_pkg::FL_OF] = (msbA ^ msbB) & (msbA ^ msbD);
endmodule // sub_flag_unit

// file: hdl/carry_compare_string_exec.sv
// Function
// - Complement carry only, two clocks.
// - Compare subtracts, flags only, no writeback.
// - Sign-extend byte immediate for word compare.
// - 3C/3D compare immediate against accumulator.
// - 80/81 reg field 7 compare immediate.
// - 38-3B register compare operand order, widths.
// - Compare lengths 3 (4 for 3D), 10, 14 clocks.
// - String compare source minus target, A6/A7.
// - Source segment overridable; target always extra.
// - Step both indexes by size, direction-selected.
// - String compare 22, narrow word 26.
// - Short string forms behave as general forms.
`timescale 1ns/1ps
module carry_compare_string_exec
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic [7:0]  opcode,
	input  wire logic [2:0]  modrmReg,
	input  wire logic        memOperand,
	input  wire logic        narrowBus,
	input  wire logic [15:0] regOperand,
	input  wire logic [15:0] rmOperand,
	input  wire logic [15:0] immediate,
	input  wire logic [15:0] accumulatorWord,
	input  wire logic [15:0] srcMemData,
	input  wire logic [15:0] dstMemData,
	input  wire logic [15:0] sourceIndexIn,
	input  wire logic [15:0] targetIndexIn,
	input  wire logic        segOverride,
	input  wire logic [1:0]  overrideSeg,
	input  wire logic        directionFlag,
	input  wire logic [5:0]  flagsIn,
	output logic             busy,
	output logic             done,
	output logic             illegalOp,
	output logic [5:0]       flagsOut,
	output logic             flagsWrite,
	output logic [15:0]      sourceIndexOut,
	output logic [15:0]      targetIndexOut,
	output logic             indexWrite,
	output logic [1:0]       srcSegSel,
	output logic [1:0]       dstSegSel
);
	typedef enum logic [1:0] {ST_IDLE, ST_RUN} state_t;

	state_t      state_r;
	logic [4:0]  count_r;
	logic        busy_r;
	logic        done_r;
	logic        illegal_r;
	logic [5:0]  flags_r;
	logic        flagsWr_r;
	logic [15:0] siOut_r;
	logic [15:0] tgtOut_r;
	logic        idxWr_r;
	logic        idxPulse_r;
	logic [1:0]  srcSeg_r;
	logic [1:0]  dstSeg_r;

	sub_flags_if sub();
	sub_flag_unit uSub (.sub(sub.alu));

	// Decode of the opcode into class, width and operand sources.
	function automatic cmp_exec_pkg::opclass_t classify(input logic [7:0] op,
		input logic [2:0] rg);
		unique case (op)
			cmp_exec_pkg::OP_CPL_CARRY: classify = cmp_exec_pkg::OPC_CPL;
			cmp_exec_pkg::OP_CMP_RMR8, cmp_exec_pkg::OP_CMP_RMR16,
			cmp_exec_pkg::OP_CMP_RRM8, cmp_exec_pkg::OP_CMP_RRM16,
			cmp_exec_pkg::OP_CMP_ACC8, cmp_exec_pkg::OP_CMP_ACC16:
				classify = cmp_exec_pkg::OPC_CMP;
			cmp_exec_pkg::OP_GRP_I8, cmp_exec_pkg::OP_GRP_I16, cmp_exec_pkg::OP_GRP_SX8:
				classify = (rg == cmp_exec_pkg::GRP_CMP_REG) ? cmp_exec_pkg::OPC_CMP
					: cmp_exec_pkg::OPC_NONE;
			cmp_exec_pkg::OP_STR_CMP8, cmp_exec_pkg::OP_STR_CMP16:
				classify = cmp_exec_pkg::OPC_STR;
			default: classify = cmp_exec_pkg::OPC_NONE;
		endcase
	endfunction

	wire cmp_exec_pkg::opclass_t opClass = classify(opcode, modrmReg);
	// Odd opcodes of each pair, plus 83, are word width.
	wire isWord = opcode[0] | (opcode == cmp_exec_pkg::OP_GRP_SX8);
	wire isAcc  = (opcode == cmp_exec_pkg::OP_CMP_ACC8) | (opcode == cmp_exec_pkg::OP_CMP_ACC16);
	wire isGrp  = (opcode == cmp_exec_pkg::OP_GRP_I8) | (opcode == cmp_exec_pkg::OP_GRP_I16)
		| (opcode == cmp_exec_pkg::OP_GRP_SX8);
	wire regFirst = (opcode == cmp_exec_pkg::OP_CMP_RRM8)
		| (opcode == cmp_exec_pkg::OP_CMP_RRM16);
	wire usesMem = memOperand & ~isAcc;

	// Immediate byte sign-extended for the 83 form.
	wire [15:0] sxImm = {{8{immediate[7]}}, immediate[7:0]};
	wire [15:0] immSel = (opcode == cmp_exec_pkg::OP_GRP_SX8) ? sxImm : immediate;

	// Operand selection per compare form.
	wire [15:0] cmpFirst = isAcc ? accumulatorWord
		: (regFirst ? regOperand : rmOperand);
	wire [15:0] cmpSecond = (isAcc | isGrp) ? immSel
		: (regFirst ? rmOperand : regOperand);

	// String compare takes source minus target.
	wire isStr = (opClass == cmp_exec_pkg::OPC_STR);
	assign sub.minuend    = isStr ? srcMemData : cmpFirst;
	assign sub.subtrahend = isStr ? dstMemData : cmpSecond;
	assign sub.wordOp     = isWord;

	// Cycle count chosen by class, operand location and bus width.
	wire [4:0] cmpLen = usesMem ? ((narrowBus & isWord) ? cmp_exec_pkg::CLK_CMP_MEMN
		: cmp_exec_pkg::CLK_CMP_MEM)
		: ((opcode == cmp_exec_pkg::OP_CMP_ACC16) ? cmp_exec_pkg::CLK_CMP_ACCW
		: cmp_exec_pkg::CLK_CMP_REG);
	wire [4:0] strLen = (narrowBus & isWord) ? cmp_exec_pkg::CLK_STR_NW
		: cmp_exec_pkg::CLK_STR;
	wire [4:0] opLen = (opClass == cmp_exec_pkg::OPC_CPL) ? cmp_exec_pkg::CLK_CPL_CARRY
		: (isStr ? strLen : cmpLen);

	// Index step, negated when the direction flag is set.
	wire [15:0] step    = isWord ? cmp_exec_pkg::STEP_WORD : cmp_exec_pkg::STEP_BYTE;
	wire [15:0] siNext  = directionFlag ? sourceIndexIn - step : sourceIndexIn + step;
	wire [15:0] tgtNext = directionFlag ? targetIndexIn - step : targetIndexIn + step;
	wire [1:0]  srcSeg  = segOverride ? overrideSeg : 2'(cmp_exec_pkg::SEG_DATA);
	wire [1:0]  dstSeg  = 2'(cmp_exec_pkg::SEG_EXTRA);

	// Carry toggled, other flags held.
	wire [5:0] carryFlipFlags = flagsIn ^ (6'h01 << cmp_exec_pkg::FL_CARRY);
	wire accept = start & (state_r == ST_IDLE);
	wire lastCycle = (state_r == ST_RUN) & (count_r == 5'h02);

	// Sequencer: count down the operation length, retire on last clock.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			count_r <= 5'h00;
		end
		else if (accept && opClass != cmp_exec_pkg::OPC_NONE)
		begin
			state_r <= ST_RUN;
			count_r <= opLen;
		end
		else if (state_r == ST_RUN)
		begin
			state_r <= lastCycle ? ST_IDLE : ST_RUN;
			count_r <= count_r - 5'h01;
		end
	end

	// Operation result captured at acceptance and output at once; only the write strobes wait for retirement.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flags_r  <= cmp_exec_pkg::FLAGS_RST;
			siOut_r  <= 16'h0000;
			tgtOut_r <= 16'h0000;
			srcSeg_r <= 2'(cmp_exec_pkg::SEG_DATA);
			dstSeg_r <= 2'(cmp_exec_pkg::SEG_EXTRA);
			idxWr_r  <= 1'b0;
		end
		else if (accept && opClass != cmp_exec_pkg::OPC_NONE)
		begin
			flags_r  <= (opClass == cmp_exec_pkg::OPC_CPL) ? carryFlipFlags : sub.flags;
			siOut_r  <= siNext;
			tgtOut_r <= tgtNext;
			srcSeg_r <= srcSeg;
			dstSeg_r <= dstSeg;
			idxWr_r  <= isStr;
		end
	end

	// Handshake outputs; no result bus exists, so nothing is written back.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_r    <= 1'b0;
			done_r    <= 1'b0;
			flagsWr_r <= 1'b0;
			illegal_r <= 1'b0;
			idxPulse_r <= 1'b0;
		end
		else
		begin
			busy_r    <= (accept && opClass != cmp_exec_pkg::OPC_NONE) | (busy_r & ~lastCycle);
			done_r    <= lastCycle;
			flagsWr_r <= lastCycle;
			illegal_r <= accept && opClass == cmp_exec_pkg::OPC_NONE;
			idxPulse_r <= lastCycle & idxWr_r;
		end
	end

	assign busy           = busy_r;
	assign done           = done_r;
	assign illegalOp      = illegal_r;
	assign flagsOut       = flags_r;
	assign flagsWrite     = flagsWr_r;
	assign sourceIndexOut = siOut_r;
	assign targetIndexOut = tgtOut_r;
	assign indexWrite     = idxPulse_r;
	assign srcSegSel      = srcSeg_r;
	assign dstSegSel      = dstSeg_r;

	// Counts busy cycles; done follows one cycle after the last of them.
	int unsigned lenCnt_r;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			lenCnt_r <= 0;
		else
			lenCnt_r <= busy_r ? lenCnt_r + 1 : 0;
	end

	// A carry complement retires two clocks after acceptance.
	sequence carryFlipStart;
		start && state_r == ST_IDLE && opcode == cmp_exec_pkg::OP_CPL_CARRY;
	endsequence
	AST_FLIP_TWO_CLOCKS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		carryFlipStart |-> !done ##1 !done ##1 done) else $error("carry flip length wrong");
	AST_FLIP_ONLY_CARRY: assert property (@(posedge ref_clk) disable iff (!rst_n)
		carryFlipStart |=> (flagsOut == ($past(flagsIn) ^ 6'h01)))
		else $error("carry flip flags wrong");
	AST_NO_INDEX_ON_CMP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start && state_r == ST_IDLE && opClass == cmp_exec_pkg::OPC_CMP
		|-> ##[1:14] done && !indexWrite) else $error("compare touched index");
	AST_SX_IMM: assert property (@(posedge ref_clk) disable iff (!rst_n)
		opcode == cmp_exec_pkg::OP_GRP_SX8 |-> sub.subtrahend[15:8] == {8{immediate[7]}})
		else $error("sign extension wrong");
	AST_ACC_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
		isAcc |-> sub.minuend == accumulatorWord && sub.subtrahend == immediate)
		else $error("accumulator operand wrong");
	AST_GRP_REG7: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start && state_r == ST_IDLE && isGrp && modrmReg != cmp_exec_pkg::GRP_CMP_REG
		|=> illegalOp && !busy) else $error("group decode wrong");
	AST_REG_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n)
		regFirst |-> sub.minuend == regOperand) else $error("operand order wrong");
	AST_CMP_MEM_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start && state_r == ST_IDLE && opClass == cmp_exec_pkg::OPC_CMP && usesMem && !narrowBus
		|-> ##10 done) else $error("memory compare length wrong");
	AST_STR_OPERANDS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		isStr |-> sub.minuend == srcMemData && sub.subtrahend == dstMemData)
		else $error("string operands wrong");
	AST_DST_SEG: assert property (@(posedge ref_clk) disable iff (!rst_n)
		dstSegSel == 2'(cmp_exec_pkg::SEG_EXTRA)) else $error("target segment overridden");
	AST_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start && state_r == ST_IDLE && opcode == cmp_exec_pkg::OP_STR_CMP16 && !directionFlag
		|=> sourceIndexOut == $past(sourceIndexIn) + 16'h0002) else $error("index step wrong");
	AST_STR_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done && idxWr_r |-> lenCnt_r + 1 == cmp_exec_pkg::CLK_STR
		|| lenCnt_r + 1 == cmp_exec_pkg::CLK_STR_NW) else $error("string length wrong");
	AST_ZERO_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
		isWord && sub.minuend == sub.subtrahend |-> sub.flags[cmp_exec_pkg::FL_ZF]
		&& !sub.flags[cmp_exec_pkg::FL_CARRY]) else $error("equal flags wrong");
	AST_SHORT_FORM: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start && state_r == ST_IDLE && opcode == cmp_exec_pkg::OP_STR_CMP8 && !segOverride
		|=> srcSegSel == 2'(cmp_exec_pkg::SEG_DATA)) else $error("short form segment wrong");
endmodule // carry_compare_string_exec

// file: dv/tb_top.sv
`timescale 1ns/1ps
// Counts every comparison and reports a mismatch at once.
`define CHK(got, exp) \
	begin \
		samplesChecked++; \
		if ((got) !== (exp)) \
		begin \
			errorCnt++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end
module tb_top;
	logic        ref_clk, rst_n, start, memOperand, narrowBus, segOverride, directionFlag;
	logic [7:0]  opcode;
	logic [2:0]  modrmReg;
	logic [15:0] regOperand, rmOperand, immediate, accumulatorWord, srcMemData, dstMemData;
	logic [15:0] sourceIndexIn, targetIndexIn, sourceIndexOut, targetIndexOut;
	logic [1:0]  overrideSeg, srcSegSel, dstSegSel;
	logic [5:0]  flagsIn, flagsOut;
	logic        busy, done, illegalOp, flagsWrite, indexWrite;
	int          errorCnt, samplesChecked, cycles;

	carry_compare_string_exec DUT (.ref_clk(ref_clk), .rst_n(rst_n), .start(start),
		.opcode(opcode), .modrmReg(modrmReg), .memOperand(memOperand), .narrowBus(narrowBus),
		.regOperand(regOperand), .rmOperand(rmOperand), .immediate(immediate),
		.accumulatorWord(accumulatorWord), .srcMemData(srcMemData), .dstMemData(dstMemData),
		.sourceIndexIn(sourceIndexIn), .targetIndexIn(targetIndexIn),
		.segOverride(segOverride), .overrideSeg(overrideSeg), .directionFlag(directionFlag),
		.flagsIn(flagsIn), .busy(busy), .done(done), .illegalOp(illegalOp),
		.flagsOut(flagsOut), .flagsWrite(flagsWrite), .sourceIndexOut(sourceIndexOut),
		.targetIndexOut(targetIndexOut), .indexWrite(indexWrite), .srcSegSel(srcSegSel),
		.dstSegSel(dstSegSel));

	// Reference flags of a subtraction a minus b: overflow down to carry, bits 5..0.
	function automatic logic [5:0] subFl(input logic [15:0] a, input logic [15:0] b,
		input logic w);
		logic [16:0] d;
		logic [4:0]  lo;
		logic        sa, sb, sr;
		d = w ? {1'b0, a} - {1'b0, b} : {9'h000, a[7:0]} - {9'h000, b[7:0]};
		lo = {1'b0, a[3:0]} - {1'b0, b[3:0]};
		sa = w ? a[15] : a[7];
		sb = w ? b[15] : b[7];
		sr = w ? d[15] : d[7];
		return {(sa != sb) && (sr != sa), sr, w ? d[15:0] == 16'h0000 : d[7:0] == 8'h00,
			lo[4], ~^d[7:0], w ? d[16] : d[8]};
	endfunction

	// Issues one opcode and counts cycles from the start cycle to done.
	task automatic runOp(input logic [7:0] op, input logic [2:0] rg, input logic mem,
		input logic nar, output int n, output logic fw, output logic iw);
		n = 0;
		@(posedge ref_clk);
		start <= 1'b1;
		opcode <= op;
		modrmReg <= rg;
		memOperand <= mem;
		narrowBus <= nar;
		do
		begin
			@(posedge ref_clk);
			start <= 1'b0;
			#1;
			n++;
			if (n == 1)
				`CHK(busy, 1'b1)
		end
		while (done !== 1'b1 && n < 40);
		fw = flagsWrite;
		iw = indexWrite;
	endtask

	// Two back-to-back carry complements; only the carry bit may change.
	task automatic testCarryFlip();
		int   n;
		logic fw, iw;
		@(posedge ref_clk);
		flagsIn <= 6'h2A;
		repeat (2)
		begin
			runOp(8'hF5, 3'h0, 1'b0, 1'b1, n, fw, iw);
			`CHK(n, 2)
			`CHK(flagsOut, 6'h2B)
			`CHK(fw, 1'b1)
		end
	endtask

	// Every compare form: operand order, widths, sign extension, lengths, flags only.
	task automatic testCmp();
		logic [7:0]  ops[11] = '{8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h80, 8'h81,
			8'h83, 8'h83, 8'h38};
		int          kind[11] = '{0, 0, 1, 1, 2, 2, 3, 3, 3, 3, 0};
		logic        mem[11] = '{0, 1, 1, 1, 0, 0, 1, 0, 1, 0, 1};
		logic        nar[11] = '{0, 1, 1, 0, 0, 1, 0, 0, 1, 0, 1};
		int          len[11] = '{3, 14, 10, 10, 3, 4, 10, 3, 14, 3, 10};
		logic        w[11] = '{0, 1, 0, 1, 0, 1, 0, 1, 1, 1, 0};
		logic [15:0] imv[11] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00F3, 16'h00F3,
			16'h00F3, 16'h00F3, 16'h00F3, 16'hFF73, 16'h0000};
		logic [15:0] a, b, imm;
		int          n;
		logic        fw, iw;
		for (int i = 0; i < 11; i++)
		begin
			@(posedge ref_clk);
			regOperand <= 16'h8001;
			rmOperand <= 16'h7FF0;
			accumulatorWord <= 16'h0050;
			immediate <= imv[i];
			flagsIn <= 6'h3F;
			imm = (ops[i] == 8'h83) ? {{8{imv[i][7]}}, imv[i][7:0]} : imv[i];
			a = (kind[i] == 1) ? 16'h8001 : (kind[i] == 2) ? 16'h0050 : 16'h7FF0;
			b = (kind[i] == 0) ? 16'h8001 : (kind[i] == 1) ? 16'h7FF0 : imm;
			runOp(ops[i], ops[i][7] ? 3'h7 : 3'h2, mem[i], nar[i], n, fw, iw);
			`CHK(n, len[i])
			`CHK(flagsOut, subFl(a, b, w[i]))
			`CHK({fw, iw}, 2'b10)
		end
	endtask

	// String compare in both sizes, both directions, with and without override.
	task automatic testStr();
		logic [15:0] stp;
		int          n;
		logic        fw, iw;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge ref_clk);
			srcMemData <= 16'h1280;
			dstMemData <= 16'h12FF;
			sourceIndexIn <= 16'h0100;
			targetIndexIn <= 16'h0200;
			directionFlag <= i[1];
			segOverride <= i[2];
			overrideSeg <= 2'h2;
			stp = i[0] ? (i[1] ? 16'hFFFE : 16'h0002) : (i[1] ? 16'hFFFF : 16'h0001);
			runOp(i[0] ? 8'hA7 : 8'hA6, 3'h0, 1'b1, i[1], n, fw, iw);
			`CHK(n, (i[0] && i[1]) ? 26 : 22)
			`CHK(flagsOut, subFl(16'h1280, 16'h12FF, i[0]))
			`CHK({fw, iw}, 2'b11)
			`CHK(sourceIndexOut, 16'h0100 + stp)
			`CHK(targetIndexOut, 16'h0200 + stp)
			`CHK(srcSegSel, i[2] ? 2'h2 : 2'h3)
			`CHK(dstSegSel, 2'h0)
		end
	endtask

	// Group opcode with a non-compare reg field is refused without completing.
	task automatic testIllegal();
		int seen;
		seen = 0;
		@(posedge ref_clk);
		start <= 1'b1;
		opcode <= 8'h80;
		modrmReg <= 3'h3;
		@(posedge ref_clk);
		start <= 1'b0;
		#1;
		`CHK(illegalOp, 1'b1)
		`CHK(busy, 1'b0)
		repeat (30)
		begin
			@(posedge ref_clk);
			#1;
			seen += (done === 1'b1);
		end
		`CHK(seen, 0)
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("errors=%0d checks=%0d", errorCnt, samplesChecked);
		if (errorCnt == 0 && samplesChecked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Free-running core clock.
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Cuts a hang short well beyond the expected run length.
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errorCnt++;
			conclude();
		end
	end

	// Main sequence.
	initial
	begin
		{rst_n, start, memOperand, narrowBus, segOverride, directionFlag} = 6'h00;
		{opcode, modrmReg, overrideSeg, flagsIn} = 19'h00000;
		{regOperand, rmOperand, immediate, accumulatorWord} = 64'h0;
		{srcMemData, dstMemData, sourceIndexIn, targetIndexIn} = 64'h0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		`CHK({busy, srcSegSel, dstSegSel}, 5'h0C)
		testCarryFlip();
		testCmp();
		testStr();
		testIllegal();
		conclude();
	end
endmodule // tb_top
